// ### src/xgp_lane.sv
// Lane logic: XAUI channel alignment and skip-column rate matching,
// gigabit 8b/10b transmit with idle substitution and reset comma burst.
// Assumes word aligner, deskew FIFOs and serializer sit outside.
`timescale 1ns/1ps
`include "xgp_cfg.svh"

module xgp_lane (
    input  wire logic              i_clk_sys,
    input  wire logic              i_srst,
    input  wire logic              i_ce,
    input  wire logic [3:0]        i_lane_sync,
    input  wire logic [3:0]        i_a_in,
    input  wire logic [3:0]        i_a_out,
    output logic      [3:0]        o_lane_sync,
    output logic                   o_deskew_go,
    output logic                   o_chan_aligned,
    input  wire xgp_pkg::xgp_col_t i_rm_col,
    input  wire logic              i_rm_wr,
    input  wire logic              i_rm_rd,
    output xgp_pkg::xgp_col_t      o_rm_col,
    output logic                   o_rm_vld,
    output logic      [3:0]        o_rm_del,
    output logic      [3:0]        o_rm_ins,
    output logic      [3:0]        o_rm_fill,
    input  wire xgp_pkg::xgp_sym_t i_tx_sym,
    output logic                   o_tx_ready,
    output logic      [9:0]        o_tx_code,
    input  wire logic              i_recov_clk,
    input  wire logic              i_recov_pin_en,
    output logic                   o_recov_clk_pin
);
    import xgp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Constants and functions

    localparam int RATE_PPM = `XGP_RATE_PPM;
    localparam int CLK_MHZ  = `XGP_CLK_MHZ;

    localparam logic [5:0] T6 [32] = '{
        6'b100111, 6'b011101, 6'b101101, 6'b110001,
        6'b110101, 6'b101001, 6'b011001, 6'b111000,
        6'b111001, 6'b100101, 6'b010101, 6'b110100,
        6'b001101, 6'b101100, 6'b011100, 6'b010111,
        6'b011011, 6'b100011, 6'b010011, 6'b110010,
        6'b001011, 6'b101010, 6'b011010, 6'b111010,
        6'b110011, 6'b100110, 6'b010110, 6'b110110,
        6'b001110, 6'b101110, 6'b011110, 6'b101011};

    localparam logic [3:0] T4 [8] = '{
        4'b1011, 4'b1001, 4'b0101, 4'b1100,
        4'b1101, 4'b1010, 4'b0110, 4'b1110};

    // Skip column: K28.0 on all four lanes at once
    function automatic logic is_skip(input xgp_col_t c);
        logic s;
        s = 1'b1;
        for (int i = 0; i < 4; i++) begin
            s = s & c[i].ctrl & (c[i].data == `XGP_K28_0);
        end
        return s;
    endfunction

    // Returns {next disparity, code}; code bit 0 is sent first
    function automatic logic [10:0] enc(input xgp_sym_t s,
                                        input logic     rd);
        logic [5:0] b6;
        logic [3:0] b4;
        logic [4:0] x;
        logic [9:0] c;
        logic [9:0] o;
        logic       r;
        logic       alt;
        logic       k28;
        x   = s.data[4:0];
        k28 = s.ctrl && x == 5'h1C;
        b6 = (s.ctrl && x == 5'h1C) ? 6'b001111 : T6[x];
        if (rd && ($countones(b6) != 3 || b6 == 6'b111000)) begin
            b6 = ~b6;
        end
        r   = rd ^ ($countones(b6) != 3);
        b4  = T4[s.data[7:5]];
        alt = (s.data[7:5] == 3'd7) && (s.ctrl ||
              (!r && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
              (r && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
        if (alt) begin
            b4 = 4'b0111;
        end
        if (r && ($countones(b4) != 2 || b4 == 4'b1100)) begin
            b4 = ~b4;
        end
        // K28 from positive disparity is the full complement
        if (k28 && rd && $countones(b4) == 2 && b4 != 4'b1100) begin
            b4 = ~b4;
        end
        c = {b6, b4};
        for (int i = 0; i < 10; i++) begin
            o[i] = c[9-i];
        end
        return {r ^ ($countones(b4) != 2), o};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    xgp_st_t  st_reg;
    xgp_st_t  st_next;
    xgp_sym_t tx_in;
    logic     active;
    logic     wr_ok;
    logic     drop;
    logic     rd_ok;
    logic     ins;
    logic     pop;
    logic     push;
    logic [3:0] seen_n;
    logic [10:0] enc_res;

    always_comb begin
        st_next = st_reg;
        seen_n  = st_reg.seen | i_a_in;
        st_next.go   = 1'b0;
        st_next.sync = i_lane_sync;

        ////////////////////////////////////////////////////////////////
        // Deskew release and channel alignment
        case (st_reg.al)
            AL_WAIT: begin
                if (st_reg.seen == 4'h0 && i_a_in == 4'h0) begin
                    st_next.win = 4'h0;
                end else if (&seen_n) begin
                    st_next.go   = 1'b1;
                    st_next.al   = AL_ACQ;
                    st_next.acnt = 3'd0;
                    st_next.seen = 4'h0;
                    st_next.win  = 4'h0;
                end else if (st_reg.win == 4'(`XGP_SKEW_WIN - 1)) begin
                    st_next.seen = 4'h0;
                    st_next.win  = 4'h0;
                end else begin
                    st_next.seen = seen_n;
                    st_next.win  = st_reg.win + 4'h1;
                end
            end
            AL_ACQ: begin
                if (&i_a_out) begin
                    st_next.acnt = st_reg.acnt + 3'd1;
                    if (st_reg.acnt == 3'(`XGP_ACQ_COLS)) begin
                        st_next.al      = AL_LOCK;
                        st_next.aligned = 1'b1;
                        st_next.acnt    = 3'd0;
                    end
                end else if (|i_a_out) begin
                    st_next.al   = AL_WAIT;
                    st_next.acnt = 3'd0;
                end
            end
            AL_LOCK: begin
                if (&i_a_out) begin
                    st_next.acnt = 3'd0;
                end else if (|i_a_out) begin
                    st_next.acnt = st_reg.acnt + 3'd1;
                    if (st_reg.acnt == 3'(`XGP_LOSS_COLS - 1)) begin
                        st_next.al      = AL_WAIT;
                        st_next.aligned = 1'b0;
                        st_next.acnt    = 3'd0;
                    end
                end
            end
            default: begin
                st_next.al = AL_WAIT;
            end
        endcase
        if (!(&i_lane_sync)) begin
            st_next.al      = AL_WAIT;
            st_next.aligned = 1'b0;
            st_next.acnt    = 3'd0;
            st_next.seen    = 4'h0;
            st_next.win     = 4'h0;
            st_next.go      = 1'b0;
        end

        ////////////////////////////////////////////////////////////////
        // Rate match FIFO, sized for the ppm offset
        active = (&i_lane_sync) & st_reg.aligned;
        wr_ok  = i_rm_wr && st_reg.fill != 4'(`XGP_RM_DEPTH);
        drop   = active && wr_ok && is_skip(i_rm_col) &&
                 st_reg.fill >= 4'(`XGP_RM_HI);
        rd_ok  = i_rm_rd && st_reg.fill != 4'h0;
        ins    = active && rd_ok && is_skip(st_reg.mem[st_reg.rp]) &&
                 st_reg.fill <= 4'(`XGP_RM_LO);
        pop    = rd_ok && !ins;
        push   = wr_ok && !drop;
        st_next.rvld = rd_ok;
        st_next.del  = drop;
        st_next.ins  = ins;
        if (rd_ok) begin
            st_next.rdat = st_reg.mem[st_reg.rp];
        end
        if (push) begin
            st_next.mem[st_reg.wp] = i_rm_col;
            st_next.wp = st_reg.wp + 3'd1;
        end
        if (pop) begin
            st_next.rp = st_reg.rp + 3'd1;
        end
        st_next.fill = st_reg.fill + {3'd0, push} - {3'd0, pop};

        ////////////////////////////////////////////////////////////////
        // Gigabit transmit: comma burst, idle substitution, encoder
        tx_in = i_tx_sym;
        if (st_reg.burst != 2'd0) begin
            tx_in = '{ctrl: 1'b1, data: `XGP_K28_5};
            st_next.burst = st_reg.burst - 2'd1;
        end else if (st_reg.prev_k && !i_tx_sym.ctrl &&
                     i_tx_sym.data != `XGP_D21_5 &&
                     i_tx_sym.data != `XGP_D2_2) begin
            tx_in.data = st_reg.rd_comma ? `XGP_D5_6
                                         : `XGP_D16_2;
        end
        st_next.prev_k = tx_in.ctrl && tx_in.data == `XGP_K28_5;
        if (st_next.prev_k) begin
            st_next.rd_comma = st_reg.rd;
        end
        enc_res      = enc(tx_in, st_reg.rd);
        st_next.rd   = enc_res[10];
        st_next.code = enc_res[9:0];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_reg       <= '0;
            st_reg.burst <= `XGP_BURST;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_lane_sync     = st_reg.sync;
    assign o_deskew_go     = st_reg.go;
    assign o_chan_aligned  = st_reg.aligned;
    assign o_rm_col        = st_reg.rdat;
    assign o_rm_vld        = st_reg.rvld;
    assign o_rm_del        = {4{st_reg.del}};
    assign o_rm_ins        = {4{st_reg.ins}};
    assign o_rm_fill       = st_reg.fill;
    assign o_tx_ready      = st_reg.burst == 2'd0;
    assign o_tx_code       = st_reg.code;
    assign o_recov_clk_pin = i_recov_clk & i_recov_pin_en;

endmodule

// ### src/xgp_cfg.svh
// Constants for the XAUI / gigabit lane logic.
// Assumes a single 125 MHz system clock.
`ifndef XGP_CFG_SVH
`define XGP_CFG_SVH

`define XGP_CLK_MHZ      125
`define XGP_SER_MHZ      625
`define XGP_PAR_MHZ      125
`define XGP_RATE_PPM     200
`define XGP_SKEW_WIN     10
`define XGP_ACQ_COLS     3
`define XGP_LOSS_COLS    4
`define XGP_BURST        2'd3
`define XGP_RM_DEPTH     8
`define XGP_RM_HI        6
`define XGP_RM_LO        2
`define XGP_K28_0        8'h1C
`define XGP_K28_5        8'hBC
`define XGP_D5_6         8'hC5
`define XGP_D16_2        8'h50
`define XGP_D21_5        8'hB5
`define XGP_D2_2         8'h42

`endif

// ### src/xgp_pkg.sv
// Types for the XAUI / gigabit lane logic.
// Assumes xgp_cfg.svh is on the include path.
package xgp_pkg;

    typedef enum logic [1:0] {AL_WAIT, AL_ACQ, AL_LOCK} xgp_al_t;

    typedef struct packed {
        logic       ctrl;
        logic [7:0] data;
    } xgp_sym_t;

    typedef xgp_sym_t [3:0] xgp_col_t;

    typedef struct packed {
        xgp_al_t        al;
        logic [3:0]     win;
        logic [3:0]     seen;
        logic [2:0]     acnt;
        logic           go;
        logic           aligned;
        logic [3:0]     sync;
        xgp_col_t [7:0] mem;
        logic [2:0]     wp;
        logic [2:0]     rp;
        logic [3:0]     fill;
        xgp_col_t       rdat;
        logic           rvld;
        logic           del;
        logic           ins;
        logic [1:0]     burst;
        logic           rd;
        logic           rd_comma;
        logic           prev_k;
        logic [9:0]     code;
    } xgp_st_t;

endpackage

// ### tb/xgp_lane_sva.sv
// Checker for the lane logic, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "xgp_cfg.svh"
module xgp_lane_sva (
    input wire logic              i_clk_sys,
    input wire logic              i_srst,
    input wire logic              i_ce,
    input wire logic [3:0]        i_lane_sync,
    input wire logic [3:0]        i_a_out,
    input wire logic [3:0]        o_lane_sync,
    input wire logic              o_deskew_go,
    input wire logic              o_chan_aligned,
    input wire xgp_pkg::xgp_col_t i_rm_col,
    input wire logic              i_rm_wr,
    input wire logic              i_rm_rd,
    input wire xgp_pkg::xgp_col_t o_rm_col,
    input wire logic              o_rm_vld,
    input wire logic [3:0]        o_rm_del,
    input wire logic [3:0]        o_rm_ins,
    input wire logic [3:0]        o_rm_fill,
    input wire logic              o_tx_ready
);
    import xgp_pkg::*;
    localparam xgp_col_t skip_col = {4{1'b1, `XGP_K28_0}};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////
    go_pulse_a: assert property (o_deskew_go |=> !o_deskew_go)
        else $error("deskew go too long");
    align_rise_a: assert property ($rose(o_chan_aligned) |->
        $past(&i_a_out && &i_lane_sync)) else $error("aligned without column");
    align_loss_a: assert property ($fell(o_chan_aligned) |->
        $past(i_srst || !(&i_lane_sync) || (|i_a_out && !(&i_a_out))))
        else $error("aligned lost without cause");
    sync_copy_a: assert property (i_ce |=>
        o_lane_sync == $past(i_lane_sync)) else $error("lane sync copy");
    del_cause_a: assert property (o_rm_del[0] |->
        $past(i_rm_wr && i_rm_col == skip_col && o_chan_aligned
        && &i_lane_sync && o_rm_fill >= 4'h6)) else $error("bad delete");
    flag_lanes_a: assert property (o_rm_del == {4{o_rm_del[0]}}
        && o_rm_ins == {4{o_rm_ins[0]}}) else $error("flags differ");
    ins_cause_a: assert property (o_rm_ins[0] |-> o_rm_vld
        && o_rm_col == skip_col && $past(i_rm_rd && o_chan_aligned
        && o_rm_fill <= 4'h2)) else $error("bad insert");
    burst_len_a: assert property ($fell(i_srst) && i_ce |->
        !o_tx_ready [*3] ##1 o_tx_ready) else $error("burst length");
    cover property (o_deskew_go);
    cover property ($rose(o_chan_aligned));
    cover property (o_rm_del[0]);
    cover property (o_rm_ins[0]);
endmodule

bind xgp_lane xgp_lane_sva u_sva (.i_clk_sys, .i_srst, .i_ce, .i_lane_sync,
    .i_a_out, .o_lane_sync, .o_deskew_go, .o_chan_aligned, .i_rm_col,
    .i_rm_wr, .i_rm_rd, .o_rm_col, .o_rm_vld, .o_rm_del, .o_rm_ins,
    .o_rm_fill, .o_tx_ready);

// ### tb/xgp_link_peer.sv
// Far-end receive model: classifies each transmitted line code.
// Assumes bit 0 of the code is the first bit on the line.
`timescale 1ns/1ps
module xgp_link_peer (
    input  wire logic [9:0] i_code,
    output logic      [1:0] o_cls
);
    // 0 comma, 1 idle D5.6, 2 idle D16.2, 3 anything else
    always_comb begin
        case (i_code)
            10'h17C, 10'h283: o_cls = 2'h0;
            10'h1A5:          o_cls = 2'h1;
            10'h2B6, 10'h289: o_cls = 2'h2;
            default:          o_cls = 2'h3;
        endcase
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the lane logic.
// Assumes a 125 MHz clock and the far-end code classifier.
`timescale 1ns/1ps
module tb_top;
    import xgp_pkg::*;
    logic       clk = 1'b0, srst = 1'b1, ce = 1'b1, rc = 1'b0, pe = 1'b0;
    logic       wr = 1'b0, rd = 1'b0, go, al, vld, rdy, pin;
    logic [3:0] ls = 4'hF, ai = 4'h0, ao = 4'h0, ols, del, ins, fill;
    logic [1:0] cls;
    logic [9:0] code;
    xgp_col_t   cin = '0, cout;
    xgp_sym_t   sym = 9'h1FB;
    int         n_mismatch = 0, n_checks = 0, cyc = 0;
    localparam xgp_col_t   skip = {4{9'h11C}};
    localparam logic [8:0] tb_b [7] = '{9'h000, 9'h06E, 9'h018, 9'h000,
                                        9'h0B5, 9'h042, 9'h1FB};
    localparam logic [8:0] tb_p [7] = '{9'h000, 9'h000, 9'h000, 9'h1BC,
                                        9'h000, 9'h000, 9'h000};
    localparam logic [1:0] tb_e [7] = '{2'h2, 2'h2, 2'h2, 2'h1,
                                        2'h3, 2'h3, 2'h3};
    xgp_lane DUT (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce),
        .i_lane_sync(ls), .i_a_in(ai), .i_a_out(ao), .o_lane_sync(ols),
        .o_deskew_go(go), .o_chan_aligned(al), .i_rm_col(cin),
        .i_rm_wr(wr), .i_rm_rd(rd), .o_rm_col(cout), .o_rm_vld(vld),
        .o_rm_del(del), .o_rm_ins(ins), .o_rm_fill(fill), .i_tx_sym(sym),
        .o_tx_ready(rdy), .o_tx_code(code), .i_recov_clk(rc),
        .i_recov_pin_en(pe), .o_recov_clk_pin(pin));
    xgp_link_peer PEER (.i_code(code), .o_cls(cls));
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [35:0] exp, logic [35:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tx(logic [8:0] s);
        @(posedge clk);
        #1 sym = s;
    endtask
    task automatic ac(logic [3:0] i, logic [3:0] o);
        @(posedge clk);
        #1 ai = i;
        ao = o;
    endtask
    task automatic rm(logic w, logic r, xgp_col_t c);
        @(posedge clk);
        #1 wr = w;
        rd = r;
        cin = c;
        @(posedge clk);
        #1 wr = 1'b0;
        rd = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_tx();
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            #1 chk("burst comma", 2'h0, cls);
            chk("ready", k == 2, rdy);
        end
        @(posedge clk);
        #1 chk("ctrl kept", 2'h3, cls);
        for (int k = 0; k < 7; k++) begin
            tx(9'h1BC);
            tx(9'h000);
            tx(tb_p[k]);
            tx(9'h1BC);
            tx(tb_b[k]);
            @(posedge clk);
            #1 chk("idle class", tb_e[k], cls);
        end
        $display("test transmit done");
    endtask
    task automatic t_rm_off();
        ls = 4'h7;
        for (int k = 0; k < 7; k++) begin
            rm(1'b1, 1'b0, skip);
            chk("no delete", 4'h0, del);
        end
        chk("sync copy", 4'h7, ols);
        chk("fill", 4'h7, fill);
        for (int k = 0; k < 7; k++) begin
            rm(1'b0, 1'b1, '0);
            chk("no insert", 5'h10, {vld, ins});
        end
        chk("empty", 4'h0, fill);
        ls = 4'hF;
        $display("test idle matcher done");
    endtask
    task automatic t_align();
        ac(4'h1, 4'h0);
        repeat (9) ac(4'h0, 4'h0);
        ac(4'hE, 4'h0);
        for (int k = 0; k < 12; k++) begin
            ac(4'h0, 4'h0);
            chk("late go", 1'b0, go);
        end
        ac(4'h1, 4'h0);
        repeat (8) ac(4'h0, 4'h0);
        ac(4'hE, 4'h0);
        ac(4'h0, 4'h0);
        chk("go", 1'b1, go);
        ac(4'h0, 4'h0);
        chk("go pulse", 1'b0, go);
        repeat (4) ac(4'h0, 4'hF);
        chk("not aligned", 1'b0, al);
        ac(4'h0, 4'h0);
        chk("aligned", 1'b1, al);
        $display("test align done");
    endtask
    task automatic t_rm_on();
        for (int k = 1; k < 7; k++) rm(1'b1, 1'b0, 36'(k));
        rm(1'b1, 1'b0, skip);
        chk("delete", 4'hF, del);
        chk("fill held", 4'h6, fill);
        for (int k = 1; k < 7; k++) begin
            rm(1'b0, 1'b1, '0);
            chk("order", k, cout);
        end
        rm(1'b1, 1'b0, skip);
        rm(1'b1, 1'b0, 36'h7);
        rm(1'b0, 1'b1, '0);
        chk("insert", 4'hF, ins);
        chk("insert col", skip, cout);
        chk("insert fill", 4'h2, fill);
        $display("test active matcher done");
    endtask
    task automatic t_loss();
        repeat (3) ac(4'h0, 4'h3);
        ac(4'h0, 4'hF);
        repeat (3) ac(4'h0, 4'h3);
        ac(4'h0, 4'h0);
        chk("kept", 1'b1, al);
        ac(4'h0, 4'h3);
        ac(4'h0, 4'h0);
        chk("lost", 1'b0, al);
        rm(1'b0, 1'b1, '0);
        chk("off insert", 4'h0, ins);
        chk("off fill", 4'h1, fill);
        for (int k = 0; k < 4; k++) begin
            #1 {rc, pe} = 2'(k);
            #1 chk("pin", rc & pe, pin);
        end
        $display("test loss done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;
        t_tx();
        t_rm_off();
        t_align();
        t_rm_on();
        t_loss();
        results();
    end
endmodule
